// [core/ext_mem_engine.sv]
// Purpose : Latched external data memory cycle on the low port byte
// Assumes : Port inputs synchronous to clk
// Notes   : Output enables are low while the pin is driven
module ext_mem_engine (
   input  wire logic clk,
   input  wire logic rst_b,
   ext_mem_if.eng    req,
   input  wire logic [7:0]  low_port_in,
   output logic      [7:0]  low_port_out,
   output logic             low_port_oe_b,
   output logic      [15:0] high_addr,
   output logic             addr_latch_en,
   output logic             ext_write_strobe_b,
   output logic             ext_read_strobe_b
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ADDR = 2'b01,
      ST_STRB = 2'b10
   } eng_state_e;

   typedef struct packed {
      eng_state_e  st;
      logic [3:0]  cnt;
      logic        wr;
      logic [7:0]  dout;
      logic        oe_b;
      logic [15:0] hi;
      logic        ale;
      logic        wr_b;
      logic        rd_b;
      logic [7:0]  rdata;
   } eng_s;

   eng_s s_r;
   eng_s s_nxt;

   //------------------------------------------------------------
   // Address phase then strobe phase
   //------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      case (s_r.st)
         ST_IDLE: begin
            if (req.start) begin
               s_nxt.st   = ST_ADDR;
               s_nxt.wr   = req.write;
               s_nxt.dout = req.addr[7:0];
               s_nxt.hi   = req.addr[23:8];
               s_nxt.oe_b = 1'b0;
               s_nxt.ale  = 1'b1;
               s_nxt.cnt  = phy_ind_pkg::ALE_CYCLES;
            end
         end
         ST_ADDR: begin
            s_nxt.cnt = s_r.cnt - 4'h1;
            if (s_r.cnt == 4'h1) begin
               s_nxt.st   = ST_STRB;
               s_nxt.ale  = 1'b0;
               s_nxt.dout = req.wdata;
               s_nxt.oe_b = !s_r.wr;
               s_nxt.wr_b = !s_r.wr;
               s_nxt.rd_b = s_r.wr;
               s_nxt.cnt  = phy_ind_pkg::STROBE_CYCLES;
            end
         end
         ST_STRB: begin
            s_nxt.cnt = s_r.cnt - 4'h1;
            if (s_r.cnt == 4'h1) begin
               s_nxt.st   = ST_IDLE;
               s_nxt.wr_b = 1'b1;
               s_nxt.rd_b = 1'b1;
               s_nxt.oe_b = 1'b1;
               if (!s_r.wr) begin
                  s_nxt.rdata = low_port_in;
               end
            end
         end
         default: s_nxt.st = ST_IDLE;
      endcase
   end

   //------------------------------------------------------------
   // State register
   //------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '{st: ST_IDLE, cnt: 4'h0, wr: 1'b0, dout: 8'h00,
                  oe_b: 1'b1, hi: 16'h0000, ale: 1'b0, wr_b: 1'b1,
                  rd_b: 1'b1, rdata: 8'h00};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign low_port_out       = s_r.dout;
   assign low_port_oe_b      = s_r.oe_b;
   assign high_addr          = s_r.hi;
   assign addr_latch_en      = s_r.ale;
   assign ext_write_strobe_b = s_r.wr_b;
   assign ext_read_strobe_b  = s_r.rd_b;
   assign req.rdata          = s_r.rdata;
   assign req.busy           = (s_r.st != ST_IDLE); // No start term, no loop

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   a_ale_drives_addr: assert property (@(posedge clk) disable iff (!rst_b)
      addr_latch_en |-> !low_port_oe_b)
      else $error("ALE high while low port not driven");
   a_strobe_exclusive: assert property (@(posedge clk) disable iff (!rst_b)
      !(ext_write_strobe_b == 1'b0 && ext_read_strobe_b == 1'b0))
      else $error("read and write strobes both active");
   a_strobe_len: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(ext_read_strobe_b) |-> !ext_read_strobe_b [*4] ##1
      ext_read_strobe_b)
      else $error("read strobe width wrong");
   c_write_cycle: cover property (@(posedge clk) $fell(ext_write_strobe_b));
   c_read_cycle: cover property (@(posedge clk) $fell(ext_read_strobe_b));
endmodule

// [core/phy_indicator_and_mode_setup.sv]
// Purpose : PHY indicators, PHY mode setup and external memory access
// Assumes : AXI4-Lite slave, PHY status inputs synchronous to clk
// Notes   : Indicator outputs are active low levels
module phy_indicator_and_mode_setup (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        rx_diff_pair_active,
   input  wire logic        tx_diff_pair_active,
   input  wire logic        phy_collision,
   input  wire logic        phy_full_duplex,
   input  wire logic        phy_link_up,
   input  wire logic [2:0]  phy_mode_pins,
   output logic             collision_indicator_b,
   output logic             rx_activity_indicator_b,
   output logic             tx_activity_indicator_b,
   output logic             link_indicator_b,
   output logic [2:0]       phy_mode_applied,
   output logic             phy_soft_reset,
   input  wire logic [7:0]  low_port_bus_in,
   output logic      [7:0]  low_port_bus_out,
   output logic             low_port_bus_oe_b,
   output logic      [15:0] ext_high_addr,
   output logic             addr_latch_en,
   output logic             ext_write_strobe_b,
   output logic             ext_read_strobe_b
);
   typedef struct packed {
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [7:0]  phy_config_reg;
      logic [2:0]  mode;
      logic [23:0] ext_addr;
      logic [7:0]  ext_wdata;
      logic [3:0]  leds_b;
   } top_s;

   top_s s_r;
   top_s s_nxt;
   ext_mem_if mem ();

   // Decodes a byte address into a known-register flag
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == phy_ind_pkg::PHY_CONFIG_OFS) ||
               (a == phy_ind_pkg::EXT_CTRL_OFS) ||
               (a == phy_ind_pkg::EXT_ADDR_OFS) ||
               (a == phy_ind_pkg::EXT_DATA_OFS) ||
               (a == phy_ind_pkg::STATUS_OFS);
   endfunction

   logic do_write;
   logic do_read;
   logic rst_fall;

   //------------------------------------------------------------
   // Bus handshakes
   //------------------------------------------------------------
   assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
   assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
   assign s_axi_arready = !s_r.rvalid;
   assign do_write = s_r.aw_got && s_r.w_got && !s_r.bvalid;
   assign do_read  = s_axi_arvalid && s_axi_arready;

   //------------------------------------------------------------
   // Next-state logic
   //------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      mem.start = 1'b0;
      mem.write = 1'b0;
      rst_fall  = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         s_nxt.aw_got  = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_nxt.w_got  = 1'b1;
         s_nxt.w_data = s_axi_wdata;
         s_nxt.w_strb = s_axi_wstrb;
      end
      // Register writes and their side effects
      if (do_write) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got  = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp  = mapped(s_r.aw_addr) ? 2'b00 :
                        phy_ind_pkg::SLVERR_RESP[1:0];
         case (s_r.aw_addr)
            phy_ind_pkg::PHY_CONFIG_OFS: begin
               if (s_r.w_strb[0]) begin
                  s_nxt.phy_config_reg = s_r.w_data[7:0];
                  // Falling edge of the reset bit ends the pulse
                  rst_fall = s_r.phy_config_reg[phy_ind_pkg::PHY_RST_BIT]
                     && !s_r.w_data[phy_ind_pkg::PHY_RST_BIT];
               end
            end
            phy_ind_pkg::EXT_CTRL_OFS: begin
               if (s_r.w_strb[0] && s_r.w_data[0] && !mem.busy) begin
                  mem.start = 1'b1;
                  mem.write = s_r.w_data[1];
               end
            end
            phy_ind_pkg::EXT_ADDR_OFS: begin
               if (s_r.w_strb[0]) s_nxt.ext_addr[7:0] = s_r.w_data[7:0];
               if (s_r.w_strb[1]) s_nxt.ext_addr[15:8] = s_r.w_data[15:8];
               if (s_r.w_strb[2]) s_nxt.ext_addr[23:16] = s_r.w_data[23:16];
            end
            phy_ind_pkg::EXT_DATA_OFS: begin
               if (s_r.w_strb[0]) s_nxt.ext_wdata = s_r.w_data[7:0];
            end
            default: s_nxt.bvalid = 1'b1;
         endcase
      end
      if (s_r.bvalid && s_axi_bready) s_nxt.bvalid = 1'b0;
      // New mode is taken on the reset pulse; pins when not overridden
      if (s_r.phy_config_reg[phy_ind_pkg::PHY_RST_BIT] || rst_fall) begin
         s_nxt.mode = s_r.phy_config_reg[phy_ind_pkg::MODE_EN_BIT] ?
            s_r.phy_config_reg[phy_ind_pkg::MODE_LSB +: 3] :
            phy_mode_pins;
      end
      // Register reads
      if (do_read) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = mapped(s_axi_araddr) ? 2'b00 :
                        phy_ind_pkg::SLVERR_RESP[1:0];
         case (s_axi_araddr)
            phy_ind_pkg::PHY_CONFIG_OFS:
               s_nxt.rdata = {24'h000000, s_r.phy_config_reg};
            phy_ind_pkg::EXT_CTRL_OFS:
               s_nxt.rdata = {23'h000000, mem.rdata, mem.busy};
            phy_ind_pkg::EXT_ADDR_OFS:
               s_nxt.rdata = {8'h00, s_r.ext_addr};
            phy_ind_pkg::EXT_DATA_OFS:
               s_nxt.rdata = {24'h000000, s_r.ext_wdata};
            phy_ind_pkg::STATUS_OFS:
               s_nxt.rdata = {25'h0000000, s_r.mode, s_r.leds_b};
            default: s_nxt.rdata = 32'h0000_0000;
         endcase
      end
      if (s_r.rvalid && s_axi_rready) s_nxt.rvalid = 1'b0;
      // Indicators follow live status, active low, no latching
      s_nxt.leds_b[3] = !(phy_collision && !phy_full_duplex);
      s_nxt.leds_b[2] = !rx_diff_pair_active;
      s_nxt.leds_b[1] = !tx_diff_pair_active;
      s_nxt.leds_b[0] = !phy_link_up;
   end

   //------------------------------------------------------------
   // State register
   //------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '{aw_got: 1'b0, aw_addr: 8'h00, w_got: 1'b0,
                  w_data: 32'h0000_0000, w_strb: 4'h0, bvalid: 1'b0,
                  bresp: 2'b00, rvalid: 1'b0, rdata: 32'h0000_0000,
                  rresp: 2'b00,
                  phy_config_reg: phy_ind_pkg::PHY_CONFIG_RST,
                  mode: phy_ind_pkg::MODE_PINS_RST,
                  ext_addr: 24'h000000, ext_wdata: 8'h00,
                  leds_b: 4'hF};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign mem.addr  = s_r.ext_addr;
   assign mem.wdata = s_r.ext_wdata;

   //------------------------------------------------------------
   // External memory engine
   //------------------------------------------------------------
   ext_mem_engine u_eng (
      .clk                (clk),
      .rst_b              (rst_b),
      .req                (mem),
      .low_port_in        (low_port_bus_in),
      .low_port_out       (low_port_bus_out),
      .low_port_oe_b      (low_port_bus_oe_b),
      .high_addr          (ext_high_addr),
      .addr_latch_en      (addr_latch_en),
      .ext_write_strobe_b (ext_write_strobe_b),
      .ext_read_strobe_b  (ext_read_strobe_b)
   );

   // Outputs
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp  = s_r.bresp;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata  = s_r.rdata;
   assign s_axi_rresp  = s_r.rresp;
   assign collision_indicator_b   = s_r.leds_b[3];
   assign rx_activity_indicator_b = s_r.leds_b[2];
   assign tx_activity_indicator_b = s_r.leds_b[1];
   assign link_indicator_b        = s_r.leds_b[0];
   assign phy_mode_applied = s_r.mode;
   assign phy_soft_reset   = s_r.phy_config_reg[phy_ind_pkg::PHY_RST_BIT];

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   a_coll_follows: assert property (@(posedge clk) disable iff (!rst_b)
      (phy_collision && !phy_full_duplex) |=> !collision_indicator_b)
      else $error("collision indicator not low");
   a_coll_fdx_off: assert property (@(posedge clk) disable iff (!rst_b)
      phy_full_duplex |=> collision_indicator_b)
      else $error("collision shown in full duplex");
   a_rx_follows: assert property (@(posedge clk) disable iff (!rst_b)
      ##1 rx_activity_indicator_b == !$past(rx_diff_pair_active))
      else $error("receive indicator mismatch");
   a_tx_follows: assert property (@(posedge clk) disable iff (!rst_b)
      ##1 tx_activity_indicator_b == !$past(tx_diff_pair_active))
      else $error("transmit indicator mismatch");
   a_link_follows: assert property (@(posedge clk) disable iff (!rst_b)
      !phy_link_up ##1 !phy_link_up |=> link_indicator_b [*1])
      else $error("link indicator latched");
   a_link_low: assert property (@(posedge clk) disable iff (!rst_b)
      phy_link_up |=> !link_indicator_b)
      else $error("link indicator not low");
   a_mode_applied: assert property (@(posedge clk) disable iff (!rst_b)
      (phy_soft_reset && s_r.phy_config_reg[phy_ind_pkg::MODE_EN_BIT])
      |=> phy_mode_applied == $past(s_r.phy_config_reg[2:0]))
      else $error("mode not applied on reset pulse");
   a_mode_hold: assert property (@(posedge clk) disable iff (!rst_b)
      (!phy_soft_reset ##1 !phy_soft_reset) |-> $stable(phy_mode_applied))
      else $error("mode changed outside reset pulse");
   a_ale_pulse: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(addr_latch_en) |-> addr_latch_en [*2] ##1 !addr_latch_en)
      else $error("ALE width wrong");
   c_reset_pulse: cover property (@(posedge clk) $fell(phy_soft_reset));
   c_collision: cover property (@(posedge clk) $fell(collision_indicator_b));
   c_link_up: cover property (@(posedge clk) $fell(link_indicator_b));
endmodule

// [shared/ext_mem_if.sv]
// Purpose : Carries one external memory request and its result
// Assumes : One clock domain
// Notes   : start is a one-cycle pulse, busy a level
interface ext_mem_if;
   logic        start;
   logic        write;
   logic [23:0] addr;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic        busy;
   modport ctrl (output start, write, addr, wdata, input rdata, busy);
   modport eng  (input start, write, addr, wdata, output rdata, busy);
endinterface

// [shared/phy_ind_pkg.sv]
// Purpose : Constants shared by the PHY indicator and mode setup block
// Assumes : 32-bit AXI4-Lite register bus, 125 MHz clock
// Notes   : Offsets are byte addresses of aligned words
package phy_ind_pkg;
   //------------------------------------------------------------
   // Register map
   //------------------------------------------------------------
   localparam logic [7:0] PHY_CONFIG_OFS = 8'h00;
   localparam logic [7:0] EXT_CTRL_OFS   = 8'h04;
   localparam logic [7:0] EXT_ADDR_OFS   = 8'h08;
   localparam logic [7:0] EXT_DATA_OFS   = 8'h0C;
   localparam logic [7:0] STATUS_OFS     = 8'h10;
   //------------------------------------------------------------
   // Configuration fields and reset values
   //------------------------------------------------------------
   localparam int          MODE_LSB       = 0;
   localparam int          MODE_EN_BIT    = 3;
   localparam int          PHY_RST_BIT    = 5;
   localparam logic [7:0]  PHY_CONFIG_RST = 8'h00;
   localparam logic [2:0]  MODE_AUTO      = 3'h0;
   localparam logic [2:0]  MODE_PINS_RST  = 3'h0;
   //------------------------------------------------------------
   // External memory cycle timing, cycles per phase; AXI error response
   //------------------------------------------------------------
   localparam logic [3:0]  ALE_CYCLES     = 4'h2;
   localparam logic [3:0]  STROBE_CYCLES  = 4'h4;
   localparam logic [31:0] SLVERR_RESP    = 32'h0000_0002;
endpackage

// [tb/ext_mem_model.sv]
// Purpose : External byte memory with address latch beside the block
// Assumes : ALE and strobes change on clk rising edges
// Notes   : A released bus shows a pattern that moves every cycle
module ext_mem_model (
   input  wire logic        clk,
   input  wire logic        ale,
   input  wire logic [15:0] high_addr,
   input  wire logic        wr_b,
   input  wire logic        rd_b,
   input  wire logic [7:0]  bus_out,
   input  wire logic        bus_oe_b,
   output logic      [7:0]  bus_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  store [0:255];
   logic [7:0]  low_addr_r = 8'h00;
   logic [7:0]  last_r = 8'h00;
   logic [15:0] wr_high_r = 16'h0000;
   int          wr_cnt = 0;
   int          rd_cnt = 0;

   // Block drives, memory answers its read strobe, else inverse of last
   assign bus_level = !bus_oe_b ? bus_out :
                      (!rd_b ? store[low_addr_r] : ~last_r);

   // Latch low address under ALE, store data under the write strobe
   always @(posedge clk) begin
      last_r <= bus_level;
      if (ale) low_addr_r <= bus_level;
      if (!wr_b) begin
         store[low_addr_r] <= bus_level;
         wr_high_r <= high_addr;
         wr_cnt <= wr_cnt + 1;
      end
      if (!rd_b) rd_cnt <= rd_cnt + 1;
   end
endmodule

// [tb/tb.sv]
// Purpose : Self-checking bench for PHY indicators and mode setup
// Assumes : AXI4-Lite master driven on rising edges, 125 MHz clock
// Notes   : Table rows first, then hand-written awkward cases
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [4:0] in; logic [3:0] exp;} led_row_s;
   typedef struct packed {
      logic [7:0] cfg;
      logic [2:0] pins;
      logic [2:0] exp;
   } mode_row_s;
   logic        clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, low_port_bus_in;
   logic [7:0]  low_port_bus_out;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        rx_diff_pair_active, tx_diff_pair_active, phy_collision;
   logic        phy_full_duplex, phy_link_up, collision_indicator_b;
   logic        rx_activity_indicator_b, tx_activity_indicator_b;
   logic        link_indicator_b, phy_soft_reset, low_port_bus_oe_b;
   logic        addr_latch_en, ext_write_strobe_b, ext_read_strobe_b;
   logic [2:0]  phy_mode_pins, phy_mode_applied, cur;
   logic [15:0] ext_high_addr;
   int          n_errors = 0;
   int          samples_checked = 0;
   int          w0, r0;
   led_row_s    led_rows [7] = '{'{5'h00, 4'hF}, '{5'h11, 4'h6},
      '{5'h19, 4'hE}, '{5'h05, 4'hA}, '{5'h0B, 4'hC}, '{5'h06, 4'h9},
      '{5'h00, 4'hF}};
   mode_row_s   mode_rows [4] = '{'{8'h0F, 3'h1, 3'h7},
      '{8'h08, 3'h5, 3'h0}, '{8'h00, 3'h6, 3'h6}, '{8'h0B, 3'h5, 3'h3}};

   phy_indicator_and_mode_setup uut (
      .clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .rx_diff_pair_active,
      .tx_diff_pair_active, .phy_collision, .phy_full_duplex,
      .phy_link_up, .phy_mode_pins, .collision_indicator_b,
      .rx_activity_indicator_b, .tx_activity_indicator_b,
      .link_indicator_b, .phy_mode_applied, .phy_soft_reset,
      .low_port_bus_in, .low_port_bus_out, .low_port_bus_oe_b,
      .ext_high_addr, .addr_latch_en, .ext_write_strobe_b,
      .ext_read_strobe_b);

   ext_mem_model mem (.clk, .ale(addr_latch_en), .high_addr(ext_high_addr),
      .wr_b(ext_write_strobe_b), .rd_b(ext_read_strobe_b),
      .bus_out(low_port_bus_out), .bus_oe_b(low_port_bus_oe_b),
      .bus_level(low_port_bus_in));

   //------------------------------------------------------------
   // Checking and bus tasks
   //------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                         input logic [3:0] s, output logic [1:0] rs);
      logic aw_t, w_t, b_t;
      b_t = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= v;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b_t) begin
         @(negedge clk);
         aw_t = s_axi_awvalid & s_axi_awready;
         w_t = s_axi_wvalid & s_axi_wready;
         b_t = s_axi_bvalid & s_axi_bready;
         rs = s_axi_bresp;
         @(posedge clk);
         if (aw_t) s_axi_awvalid <= 1'b0;
         if (w_t) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                         output logic [1:0] rs);
      logic ar_t, r_t;
      r_t = 1'b0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!r_t) begin
         @(negedge clk);
         ar_t = s_axi_arvalid & s_axi_arready;
         r_t = s_axi_rvalid & s_axi_rready;
         v = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge clk);
         if (ar_t) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask

   // Full-word access that expects an OKAY response
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [1:0] rs;
      axi_wr(a, v, 4'hF, rs);
      chk(rs, 2'h0);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      logic [1:0] rs;
      axi_rd(a, v, rs);
      chk(rs, 2'h0);
   endtask

   task automatic wait_idle;
      do rd(phy_ind_pkg::EXT_CTRL_OFS, d); while (d[0] !== 1'b0);
   endtask

   task automatic report_and_stop;
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   //------------------------------------------------------------
   // Clock, watchdog and test sequence
   //------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      report_and_stop();
   end

   initial begin
      {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, phy_mode_pins} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h00000;
      s_axi_wdata = 32'h0000_0000;
      {phy_collision, phy_full_duplex, rx_diff_pair_active} = 3'h0;
      {tx_diff_pair_active, phy_link_up} = 2'h0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chk({low_port_bus_oe_b, addr_latch_en}, 2'h2);
      chk({ext_write_strobe_b, ext_read_strobe_b}, 2'h3);
      rd(phy_ind_pkg::PHY_CONFIG_OFS, d);
      chk(d, phy_ind_pkg::PHY_CONFIG_RST);
      foreach (led_rows[i]) begin
         @(posedge clk);
         {phy_collision, phy_full_duplex, rx_diff_pair_active,
          tx_diff_pair_active, phy_link_up} <= led_rows[i].in;
         @(posedge clk);
         @(negedge clk);
         chk({collision_indicator_b, rx_activity_indicator_b,
              tx_activity_indicator_b, link_indicator_b},
             led_rows[i].exp);
      end
      $display("test indicators done");
      cur = phy_ind_pkg::MODE_PINS_RST;
      foreach (mode_rows[i]) begin
         @(posedge clk);
         phy_mode_pins <= mode_rows[i].pins;
         wr(phy_ind_pkg::PHY_CONFIG_OFS, mode_rows[i].cfg);
         rd(phy_ind_pkg::PHY_CONFIG_OFS, d);
         chk(d, mode_rows[i].cfg);
         chk({phy_soft_reset, phy_mode_applied}, {1'b0, cur});
         wr(phy_ind_pkg::PHY_CONFIG_OFS, mode_rows[i].cfg | 8'h20);
         @(negedge clk);
         chk({phy_soft_reset, phy_mode_applied},
             {1'b1, mode_rows[i].exp});
         wr(phy_ind_pkg::PHY_CONFIG_OFS, mode_rows[i].cfg);
         @(negedge clk);
         chk({phy_soft_reset, phy_mode_applied},
             {1'b0, mode_rows[i].exp});
         cur = mode_rows[i].exp;
      end
      $display("test mode setup done");
      // Upper lanes only, unmapped places answer with an error
      axi_wr(phy_ind_pkg::PHY_CONFIG_OFS, 32'hFFFF_FFFF, 4'hE, r);
      chk(r, 2'h0);
      rd(phy_ind_pkg::PHY_CONFIG_OFS, d);
      chk(d, 32'h0000_000B);
      axi_rd(8'h40, d, r);
      chk(r, 2'h2);
      chk(d, 32'h0);
      axi_wr(8'h44, 32'h0000_0020, 4'hF, r);
      chk({r, phy_soft_reset}, 3'h4);
      phy_collision <= 1'b1;
      rd(phy_ind_pkg::STATUS_OFS, d);
      chk(d[6:0], {3'h3, 4'h7});
      $display("test register map done");
      w0 = mem.wr_cnt;
      r0 = mem.rd_cnt;
      wr(phy_ind_pkg::EXT_ADDR_OFS, 32'h0012_3456);
      wr(phy_ind_pkg::EXT_DATA_OFS, 32'h0000_00A5);
      wr(phy_ind_pkg::EXT_CTRL_OFS, 32'h0000_0003);
      wait_idle();
      chk(mem.store[8'h56], 8'hA5);
      chk(mem.wr_high_r, 16'h1234);
      chk(mem.wr_cnt - w0, phy_ind_pkg::STROBE_CYCLES);
      chk(mem.rd_cnt - r0, 0);
      wr(phy_ind_pkg::EXT_DATA_OFS, 32'h0000_005A);
      wr(phy_ind_pkg::EXT_CTRL_OFS, 32'h0000_0001);
      wait_idle();
      chk(d[8:1], 8'hA5);
      chk(mem.rd_cnt - r0, phy_ind_pkg::STROBE_CYCLES);
      chk(mem.wr_cnt - w0, phy_ind_pkg::STROBE_CYCLES);
      $display("test external memory done");
      @(posedge clk);
      rst_b <= 1'b0;
      @(negedge clk);
      chk({collision_indicator_b, phy_mode_applied}, 4'h8);
      @(posedge clk);
      rst_b <= 1'b1;
      rd(phy_ind_pkg::PHY_CONFIG_OFS, d);
      chk(d, phy_ind_pkg::PHY_CONFIG_RST);
      $display("test second reset done");
      report_and_stop();
   end
endmodule
